// *** rtl/lcp_an_end.sv ***
// link control protocol entity core and its access side end
//
// Overview of operation
// RQ1 - missing mandatory element: report, discard message
// RQ2 - unknown elements: strip, report, keep processing
// RQ3 - bad element length or code: report, discard
// RQ4 - acknowledge timer within ten percent of nominal
// RQ5 - one second timer, started on send, stopped by ack
// RQ6 - traffic on moves out of service to service
// RQ7 - traffic off stops timer, returns out of service
// RQ8 - out of service: requests and messages report error
// RQ9 - in service: request sends message, starts timer
// RQ10 - requests while awaiting ack are saved
// RQ11 - received link control answered, forwarded to management
// RQ12 - ack while awaiting returns to service; else ignored
// RQ13 - first expiry resends; second reports, returns to service
// RQ14 - ordered request queue drained only in service
// RQ15 - message under four octets reported and discarded
// RQ16 - timeout counted in clock cycles by constant
`timescale 1ns/1ps
module lcp_core #(
  parameter logic [15:0] LINK_ADDR = lcp_pkg::LINK_ADDR_DEF,
  parameter int TIMEOUT_CYCLES = lcp_pkg::ACK_WAIT_CYCLES,
  parameter int QDEPTH = lcp_pkg::QUEUE_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic mgmtTrafficOn, // start traffic pulse
  input wire logic mgmtTrafficOff, // stop traffic pulse
  input wire logic functionRequest, // function request pulse
  input wire logic [6:0] reqFunc, // requested link function
  output logic reqReady, // queue can take a request
  output logic mgmtErrorReport, // error report pulse
  output logic [2:0] errCause, // cause bits of the report
  output logic indValid, // received function forwarded
  output logic [6:0] indFunc, // forwarded function
  output logic [15:0] indAddr, // forwarded layer 3 address
  output lcp_pkg::lcp_state_t linkState, // protocol state
  input wire logic rxValid, // message from peer
  input lcp_pkg::lcp_msg_t rxMsg, // received message
  output logic txValid, // message to peer
  output lcp_pkg::lcp_msg_t txMsg // sent message
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int CW = $clog2(QDEPTH + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(TIMEOUT_CYCLES - 1); // see RQ4 RQ16
  localparam logic [CW-1:0] QFULL = CW'(QDEPTH);

  typedef struct packed {
    lcp_pkg::lcp_state_t st;
    logic [TW-1:0] tmr;
    logic expired1;
    logic [6:0] sentFn;
    logic [QDEPTH-1:0][6:0] q;
    logic [CW-1:0] cnt;
    logic ready;
    logic errValid;
    logic [2:0] cause;
    logic indValid;
    logic [6:0] indFunc;
    logic [15:0] indAddr;
    logic txValid;
    lcp_pkg::lcp_msg_t txMsg;
  } lcp_core_t;

  lcp_core_t s_r;
  lcp_core_t s_nxt;

  // ------------------------------------------------------------------
  // message helpers
  // ------------------------------------------------------------------
  // returns {report, discard}
  function automatic logic [1:0] checkMsg(lcp_pkg::lcp_msg_t m);
    logic rep;
    logic drop;
    rep = 1'b0;
    drop = 1'b0;
    if (m.octets < lcp_pkg::MIN_MSG_OCTETS) begin // see RQ15
      rep = 1'b1;
      drop = 1'b1;
    end else if (m.disc != lcp_pkg::PROTO_DISC || m.addr != LINK_ADDR || m.repeatedIe ||
                 (m.mtype != lcp_pkg::MT_LINK_CTRL && m.mtype != lcp_pkg::MT_LINK_ACK)) begin
      rep = 1'b1;
      drop = 1'b1;
    end else if (!m.fnPresent) begin // see RQ1
      rep = 1'b1;
      drop = 1'b1;
    end else if (m.fnLen != lcp_pkg::FN_IE_LEN || m.fnCode > lcp_pkg::FN_CODE_MAX) begin // see RQ3
      rep = 1'b1;
      drop = 1'b1;
    end else if (m.unknownIe) begin // see RQ2
      rep = 1'b1;
    end
    return {rep, drop};
  endfunction

  function automatic lcp_pkg::lcp_msg_t mkMsg(logic [7:0] mtype, logic [6:0] fn);
    lcp_pkg::lcp_msg_t m;
    m = '0;
    m.octets = lcp_pkg::TX_MSG_OCTETS;
    m.disc = lcp_pkg::PROTO_DISC;
    m.addr = LINK_ADDR;
    m.mtype = mtype;
    m.fnPresent = 1'b1;
    m.fnLen = lcp_pkg::FN_IE_LEN;
    m.fnCode = fn;
    return m;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [1:0] chk;
    logic expire;
    logic push;
    chk = 2'b00;
    expire = 1'b0;
    push = 1'b0;
    s_nxt = s_r;
    s_nxt.errValid = 1'b0;
    s_nxt.cause = 3'h0;
    s_nxt.indValid = 1'b0;
    s_nxt.txValid = 1'b0;
    if (s_r.st == lcp_pkg::LCP_AWAIT_ACK && s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - TW'(1); // see RQ5
    end
    expire = s_r.st == lcp_pkg::LCP_AWAIT_ACK && s_r.tmr == '0;
    if (functionRequest && s_r.ready) begin
      if (s_r.st == lcp_pkg::LCP_OUT_OF_SERVICE) begin
        s_nxt.cause[lcp_pkg::ERR_STATE_BIT] = 1'b1; // see RQ8
      end else begin
        push = 1'b1; // see RQ10
      end
    end
    if (rxValid) begin
      chk = checkMsg(rxMsg);
      s_nxt.cause[lcp_pkg::ERR_PROTO_BIT] = chk[1];
      if (!chk[0]) begin
        if (s_r.st == lcp_pkg::LCP_OUT_OF_SERVICE) begin
          s_nxt.cause[lcp_pkg::ERR_STATE_BIT] = 1'b1; // see RQ8
        end else if (rxMsg.mtype == lcp_pkg::MT_LINK_CTRL) begin
          s_nxt.txValid = 1'b1; // see RQ11
          s_nxt.txMsg = mkMsg(lcp_pkg::MT_LINK_ACK, rxMsg.fnCode);
          s_nxt.indValid = 1'b1;
          s_nxt.indFunc = rxMsg.fnCode;
          s_nxt.indAddr = rxMsg.addr;
        end else if (s_r.st == lcp_pkg::LCP_AWAIT_ACK && rxMsg.fnCode == s_r.sentFn) begin
          s_nxt.st = lcp_pkg::LCP_IN_SERVICE; // see RQ12
          s_nxt.tmr = '0; // see RQ5
        end
      end
    end else if (expire) begin
      if (!s_r.expired1) begin
        s_nxt.txValid = 1'b1; // see RQ13
        s_nxt.txMsg = mkMsg(lcp_pkg::MT_LINK_CTRL, s_r.sentFn);
        s_nxt.tmr = TMR_LOAD;
        s_nxt.expired1 = 1'b1;
      end else begin
        s_nxt.cause[lcp_pkg::ERR_TIMEOUT_BIT] = 1'b1; // see RQ13
        s_nxt.st = lcp_pkg::LCP_IN_SERVICE;
      end
    end else if (s_r.st == lcp_pkg::LCP_IN_SERVICE && s_r.cnt != '0) begin
      s_nxt.txValid = 1'b1; // see RQ9
      s_nxt.txMsg = mkMsg(lcp_pkg::MT_LINK_CTRL, s_r.q[0]);
      s_nxt.sentFn = s_r.q[0];
      s_nxt.tmr = TMR_LOAD; // see RQ5
      s_nxt.expired1 = 1'b0;
      s_nxt.st = lcp_pkg::LCP_AWAIT_ACK;
      for (int i = 0; i < QDEPTH - 1; i++) begin
        s_nxt.q[i] = s_r.q[i+1]; // see RQ14
      end
      s_nxt.cnt = s_r.cnt - CW'(1);
    end
    if (push) begin
      s_nxt.q[s_nxt.cnt] = reqFunc; // see RQ14
      s_nxt.cnt = s_nxt.cnt + CW'(1);
    end
    if (mgmtTrafficOff && s_r.st != lcp_pkg::LCP_OUT_OF_SERVICE) begin
      s_nxt.st = lcp_pkg::LCP_OUT_OF_SERVICE; // see RQ7
      s_nxt.tmr = '0;
      s_nxt.cnt = '0;
    end else if (mgmtTrafficOn && s_r.st == lcp_pkg::LCP_OUT_OF_SERVICE) begin
      s_nxt.st = lcp_pkg::LCP_IN_SERVICE; // see RQ6
    end
    s_nxt.ready = s_nxt.cnt != QFULL;
    s_nxt.errValid = |s_nxt.cause;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= lcp_pkg::LCP_OUT_OF_SERVICE;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reqReady = s_r.ready;
  assign mgmtErrorReport = s_r.errValid;
  assign errCause = s_r.cause;
  assign indValid = s_r.indValid;
  assign indFunc = s_r.indFunc;
  assign indAddr = s_r.indAddr;
  assign linkState = s_r.st;
  assign txValid = s_r.txValid;
  assign txMsg = s_r.txMsg;

endmodule

// access side end on the link
module lcp_an_end #(
  parameter logic [15:0] LINK_ADDR = lcp_pkg::LINK_ADDR_DEF,
  parameter int TIMEOUT_CYCLES = lcp_pkg::ACK_WAIT_CYCLES,
  parameter int QDEPTH = lcp_pkg::QUEUE_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic mgmtTrafficOn, // start traffic pulse
  input wire logic mgmtTrafficOff, // stop traffic pulse
  input wire logic functionRequest, // function request pulse
  input wire logic [6:0] reqFunc, // requested link function
  output logic reqReady, // queue can take a request
  output logic mgmtErrorReport, // error report pulse
  output logic [2:0] errCause, // cause bits of the report
  output logic indValid, // received function forwarded
  output logic [6:0] indFunc, // forwarded function
  output logic [15:0] indAddr, // forwarded layer 3 address
  output lcp_pkg::lcp_state_t linkState, // protocol state
  lcp_link_if.an link // message link to the exchange end
);

  lcp_core #(.LINK_ADDR(LINK_ADDR), .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .QDEPTH(QDEPTH)) u_core (
    .clk(clk),
    .rstn(rstn),
    .mgmtTrafficOn(mgmtTrafficOn),
    .mgmtTrafficOff(mgmtTrafficOff),
    .functionRequest(functionRequest),
    .reqFunc(reqFunc),
    .reqReady(reqReady),
    .mgmtErrorReport(mgmtErrorReport),
    .errCause(errCause),
    .indValid(indValid),
    .indFunc(indFunc),
    .indAddr(indAddr),
    .linkState(linkState),
    .rxValid(link.leTxValid),
    .rxMsg(link.leTxMsg),
    .txValid(link.anTxValid),
    .txMsg(link.anTxMsg)
  );

endmodule

// *** rtl/lcp_pkg.sv ***
// constants, message layout and state codes shared by both link control ends
package lcp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int ACK_WAIT_MS = 1000;
  localparam int ACK_WAIT_CYCLES = (CLK_HZ / 1000) * ACK_WAIT_MS;

  // ------------------------------------------------------------------
  // message coding
  // ------------------------------------------------------------------
  localparam logic [7:0] MIN_MSG_OCTETS = 8'h04;
  localparam logic [7:0] PROTO_DISC = 8'h48;
  localparam logic [7:0] MT_LINK_CTRL = 8'h30;
  localparam logic [7:0] MT_LINK_ACK = 8'h31;
  localparam logic [3:0] FN_IE_LEN = 4'h3;
  localparam logic [6:0] FN_CODE_MAX = 7'h07;
  localparam logic [7:0] TX_MSG_OCTETS = 8'h07;
  localparam logic [15:0] LINK_ADDR_DEF = 16'h0001;
  localparam int QUEUE_DEPTH = 4;

  // ------------------------------------------------------------------
  // error report cause bits
  // ------------------------------------------------------------------
  localparam int ERR_PROTO_BIT = 0;
  localparam int ERR_STATE_BIT = 1;
  localparam int ERR_TIMEOUT_BIT = 2;

  typedef enum logic [1:0] {
    LCP_OUT_OF_SERVICE = 2'h0,
    LCP_IN_SERVICE = 2'h1,
    LCP_AWAIT_ACK = 2'h3
  } lcp_state_t;

  typedef struct packed {
    logic [7:0] octets;
    logic [7:0] disc;
    logic [15:0] addr;
    logic [7:0] mtype;
    logic fnPresent;
    logic [3:0] fnLen;
    logic [6:0] fnCode;
    logic unknownIe;
    logic repeatedIe;
  } lcp_msg_t;

endpackage

// *** rtl/lcp_link_if.sv ***
// message link joining the access side end and the exchange side end
`timescale 1ns/1ps
interface lcp_link_if;
  logic anTxValid;
  lcp_pkg::lcp_msg_t anTxMsg;
  logic leTxValid;
  lcp_pkg::lcp_msg_t leTxMsg;

  modport an (output anTxValid, output anTxMsg, input leTxValid, input leTxMsg);
  modport le (output leTxValid, output leTxMsg, input anTxValid, input anTxMsg);
endinterface

// *** rtl/lcp_le_end.sv ***
// exchange side end on the link; same protocol engine as the access side
`timescale 1ns/1ps
module lcp_le_end #(
  parameter logic [15:0] LINK_ADDR = lcp_pkg::LINK_ADDR_DEF,
  parameter int TIMEOUT_CYCLES = lcp_pkg::ACK_WAIT_CYCLES,
  parameter int QDEPTH = lcp_pkg::QUEUE_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic mgmtTrafficOn, // start traffic pulse
  input wire logic mgmtTrafficOff, // stop traffic pulse
  input wire logic functionRequest, // function request pulse
  input wire logic [6:0] reqFunc, // requested link function
  output logic reqReady, // queue can take a request
  output logic mgmtErrorReport, // error report pulse
  output logic [2:0] errCause, // cause bits of the report
  output logic indValid, // received function forwarded
  output logic [6:0] indFunc, // forwarded function
  output logic [15:0] indAddr, // forwarded layer 3 address
  output lcp_pkg::lcp_state_t linkState, // protocol state
  lcp_link_if.le link // message link to the access end
);

  // symmetric protocol: every check, timer and transition of the access side applies here
  lcp_core #(.LINK_ADDR(LINK_ADDR), .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .QDEPTH(QDEPTH)) u_core (
    .clk(clk),
    .rstn(rstn),
    .mgmtTrafficOn(mgmtTrafficOn),
    .mgmtTrafficOff(mgmtTrafficOff),
    .functionRequest(functionRequest),
    .reqFunc(reqFunc),
    .reqReady(reqReady),
    .mgmtErrorReport(mgmtErrorReport),
    .errCause(errCause),
    .indValid(indValid),
    .indFunc(indFunc),
    .indAddr(indAddr),
    .linkState(linkState),
    .rxValid(link.anTxValid), // see RQ11
    .rxMsg(link.anTxMsg),
    .txValid(link.leTxValid),
    .txMsg(link.leTxMsg)
  );

endmodule

// *** test/lcp_link_asserts.sv ***
// assertions on the message link between the two ends
`timescale 1ns/1ps
module lcp_link_asserts (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic anTxValid, // access end sends
  input lcp_pkg::lcp_msg_t anTxMsg, // access end message
  input wire logic leTxValid, // exchange end sends
  input lcp_pkg::lcp_msg_t leTxMsg // exchange end message
);
  logic anCtrl, anAck, leAck;
  assign anCtrl = anTxValid && anTxMsg.mtype == lcp_pkg::MT_LINK_CTRL;
  assign anAck = anTxValid && anTxMsg.mtype == lcp_pkg::MT_LINK_ACK;
  assign leAck = leTxValid && leTxMsg.mtype == lcp_pkg::MT_LINK_ACK;

  // a sent message carries every mandatory element, well coded
  function automatic logic good(lcp_pkg::lcp_msg_t m);
    return m.octets == lcp_pkg::TX_MSG_OCTETS && m.disc == lcp_pkg::PROTO_DISC && m.addr == lcp_pkg::LINK_ADDR_DEF
      && m.fnPresent && m.fnLen == lcp_pkg::FN_IE_LEN && m.fnCode <= lcp_pkg::FN_CODE_MAX && !m.unknownIe
      && !m.repeatedIe && (m.mtype == lcp_pkg::MT_LINK_CTRL || m.mtype == lcp_pkg::MT_LINK_ACK);
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  an_msg_form_a: assert property (anTxValid |-> good(anTxMsg))
    else $error("access end sent a malformed message");
  le_msg_form_a: assert property (leTxValid |-> good(leTxMsg))
    else $error("exchange end sent a malformed message");
  le_ack_pair_a: assert property (leAck |-> $past(anCtrl) && leTxMsg.fnCode == $past(anTxMsg.fnCode))
    else $error("exchange ack not paired with a control message");
  an_ack_pair_a: assert property (anAck |-> $past(leTxValid) && anTxMsg.fnCode == $past(leTxMsg.fnCode))
    else $error("access ack not paired with a control message");
  le_ack_gap_a: assert property (leAck |=> !leAck)
    else $error("exchange end acked twice in a row");
  an_resend_gap_a: assert property (anCtrl ##1 !leAck |=> !anCtrl [*2])
    else $error("access end resent too early");
  an_msg_hold_a: assert property (!anTxValid |-> $stable(anTxMsg))
    else $error("access message changed while idle");
  le_msg_hold_a: assert property (!leTxValid |-> $stable(leTxMsg))
    else $error("exchange message changed while idle");
endmodule

// *** test/lcp_link_tb_top.sv ***
// two link ends face to face, plus one exchange end fed by a fault driver
`timescale 1ns/1ps
module lcp_link_tb_top;
  localparam int TO = 20;
  logic clk = 0, rstn = 0, anOn = 0, anOff = 0, anReq = 0, leOn = 0, leOff = 0, leReq = 0, fOn = 0;
  logic [6:0] anFunc = 7'h00, leIndFunc, anIndFunc;
  logic anErr, leErr, leInd, fErr, anReady, anInd;
  logic [2:0] anCause, leCause, fCause;
  logic [15:0] leIndAddr, anIndAddr;
  lcp_pkg::lcp_state_t anSt, leSt, fSt;
  lcp_pkg::lcp_msg_t m;
  int err_count = 0, n_compared = 0, seed = 85384, n, s, leErrs = 0, anSends = 0;
  int q[$], ts[$], lq[$];
  lcp_link_if lnk();
  lcp_link_if bad();
  lcp_an_end #(.TIMEOUT_CYCLES(TO)) i_lcp_an_end (.clk(clk), .rstn(rstn), .mgmtTrafficOn(anOn),
    .mgmtTrafficOff(anOff), .functionRequest(anReq), .reqFunc(anFunc), .reqReady(anReady), .mgmtErrorReport(anErr),
    .errCause(anCause), .indValid(anInd), .indFunc(anIndFunc), .indAddr(anIndAddr), .linkState(anSt), .link(lnk));
  lcp_le_end #(.TIMEOUT_CYCLES(TO)) i_lcp_le_end (.clk(clk), .rstn(rstn), .mgmtTrafficOn(leOn),
    .mgmtTrafficOff(leOff), .functionRequest(leReq), .reqFunc(anFunc), .reqReady(), .mgmtErrorReport(leErr),
    .errCause(leCause), .indValid(leInd), .indFunc(leIndFunc), .indAddr(leIndAddr), .linkState(leSt), .link(lnk));
  lcp_le_end #(.TIMEOUT_CYCLES(TO)) i_lcp_le_end2 (.clk(clk), .rstn(rstn), .mgmtTrafficOn(fOn),
    .mgmtTrafficOff(1'b0), .functionRequest(1'b0), .reqFunc(7'h00), .reqReady(), .mgmtErrorReport(fErr),
    .errCause(fCause), .indValid(), .indFunc(), .indAddr(), .linkState(fSt), .link(bad));
  lcp_link_asserts i_lcp_link_asserts (.clk(clk), .rstn(rstn), .anTxValid(lnk.anTxValid), .anTxMsg(lnk.anTxMsg),
    .leTxValid(lnk.leTxValid), .leTxMsg(lnk.leTxMsg));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input lcp_pkg::lcp_state_t got, input lcp_pkg::lcp_state_t exp);
    chk({14'h0000, got}, {14'h0000, exp});
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clk);
    sig = 1'b0;
  endtask

  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // indications at both ends must follow the request order
  always @(negedge clk) begin
    if (leErr === 1'b1) leErrs++;
    if (lnk.anTxValid === 1'b1) anSends++;
    if (leInd === 1'b1) begin
      chk(leIndFunc, q.size() > 0 ? q.pop_front() : -1);
      chk(leIndAddr, lcp_pkg::LINK_ADDR_DEF);
    end
    if (anInd === 1'b1) begin
      chk(anIndFunc, lq.size() > 0 ? lq.pop_front() : -1);
      chk(anIndAddr, lcp_pkg::LINK_ADDR_DEF);
    end
  end

  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end

  // ---------------------------
  // main sequence
  // ---------------------------
  initial begin
    bad.anTxValid = 1'b0;
    bad.anTxMsg = '0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk_state(anSt, lcp_pkg::LCP_OUT_OF_SERVICE);
    pulse(anReq);
    chk({anErr, anCause}, 4'ha);
    pulse(anOn);
    pulse(anOn);
    pulse(leOn);
    pulse(fOn);
    chk_state(anSt, lcp_pkg::LCP_IN_SERVICE);
    anReq = 1'b1;
    for (int i = 0; i < 3; i++) begin
      anFunc = 7'($random(seed) & 7);
      q.push_back(anFunc);
      @(negedge clk);
    end
    anReq = 1'b0;
    n = 0;
    while ((q.size() != 0 || anSt !== lcp_pkg::LCP_IN_SERVICE) && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(q.size(), 0);
    anFunc = 7'h02;
    lq.push_back(anFunc);
    pulse(leReq);
    repeat (5) @(negedge clk);
    chk(lq.size(), 0);
    chk_state(leSt, lcp_pkg::LCP_IN_SERVICE);
    pulse(leOff);
    chk_state(leSt, lcp_pkg::LCP_OUT_OF_SERVICE);
    anFunc = 7'h05;
    pulse(anReq);
    n = 0;
    while (n < 100 && anErr !== 1'b1) begin
      @(negedge clk);
      n++;
      if (lnk.anTxValid === 1'b1) ts.push_back(n);
    end
    chk(ts.size(), 2);
    chk(ts[1] - ts[0] inside {[18:22]}, 1);
    chk(n - ts[1] inside {[18:22]}, 1);
    chk({anErr, anCause}, 4'hc);
    chk_state(anSt, lcp_pkg::LCP_IN_SERVICE);
    chk(leErrs, 2);
    pulse(anReq);
    @(negedge clk);
    pulse(anOff);
    chk_state(anSt, lcp_pkg::LCP_OUT_OF_SERVICE);
    s = anSends;
    repeat (50) @(negedge clk);
    chk(anSends, s);
    pulse(anOn);
    anReq = 1'b1;
    repeat (6) @(negedge clk);
    anReq = 1'b0;
    chk(anReady, 0);
    pulse(anOff);
    chk(anReady, 1);
    for (int i = 0; i < 11; i++) begin
      m = '{octets: lcp_pkg::TX_MSG_OCTETS, disc: lcp_pkg::PROTO_DISC, addr: lcp_pkg::LINK_ADDR_DEF,
        mtype: lcp_pkg::MT_LINK_CTRL, fnPresent: 1'b1, fnLen: lcp_pkg::FN_IE_LEN, fnCode: 7'($random(seed) & 7),
        unknownIe: 1'b0, repeatedIe: 1'b0};
      case (i)
        1: m.octets = 8'h03;
        2: m.fnPresent = 1'b0;
        3: m.fnLen = 4'h2;
        4: m.fnCode = 7'h08;
        5: m.unknownIe = 1'b1;
        6: m.mtype = lcp_pkg::MT_LINK_ACK;
        7: m.disc = 8'h49;
        8: m.repeatedIe = 1'b1;
        9: m.addr = 16'h0002;
        10: m.mtype = 8'h32;
        default: ;
      endcase
      bad.anTxMsg = m;
      pulse(bad.anTxValid);
      chk({fErr, fCause}, (i == 0 || i == 6) ? 4'h0 : 4'h9);
      chk(bad.leTxValid, i == 0 || i == 5);
      if (i == 0 || i == 5) chk(bad.leTxMsg.fnCode, m.fnCode);
      chk_state(fSt, lcp_pkg::LCP_IN_SERVICE);
      @(negedge clk);
    end
    report_and_stop();
  end
endmodule
